// >>> logic/fsr_cfg.svh
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// ****************************************************************
// Register selects used by status reads and status writes.
// ****************************************************************
`define FSR_SEL_SR1 2'h1
`define FSR_SEL_SR2 2'h2
`define FSR_SEL_SR3 2'h3

// ****************************************************************
// Field positions.
// ****************************************************************
`define FSR_BIT_SRP 7
`define FSR_BIT_SEC 6
`define FSR_BIT_TB 5
`define FSR_BIT_BP_HI 4
`define FSR_BIT_BP_LO 2
`define FSR_BIT_WEL 1
`define FSR_BIT_BUSY 0
`define FSR_BIT_SUS 7
`define FSR_BIT_CMP 6
`define FSR_BIT_LB_HI 5
`define FSR_BIT_LB_LO 3
`define FSR_BIT_QE 1
`define FSR_BIT_PAUSE_OR_RESET_PIN_SELECT 7
`define FSR_BIT_DRV_HI 6
`define FSR_BIT_DRV_LO 5
`define FSR_BIT_HFM 4

// ****************************************************************
// Writable masks and reset values.
// ****************************************************************
`define FSR_SR1_MASK 8'hfc
`define FSR_SR2_MASK 8'h7a
`define FSR_SR2_VMASK 8'h42
`define FSR_SR2_LBMASK 8'h38
`define FSR_SR3_MASK 8'hf0
`define FSR_SR1_RST 8'h00
`define FSR_SR2_RST 8'h00
`define FSR_SR3_RST 8'h10

// ****************************************************************
// Embedded operation times in ns and the clock period in ns.
// ****************************************************************
`define FSR_CLK_NS 40
`define FSR_T_WRSR_NS 8000
`define FSR_T_PROG_NS 16000
`define FSR_T_SE_NS 40000
`define FSR_T_BE_NS 80000
`define FSR_T_CE_NS 160000
`define FSR_WRSR_CYC 16'(`FSR_T_WRSR_NS / `FSR_CLK_NS)
`define FSR_PROG_CYC 16'(`FSR_T_PROG_NS / `FSR_CLK_NS)
`define FSR_SE_CYC 16'(`FSR_T_SE_NS / `FSR_CLK_NS)
`define FSR_BE_CYC 16'(`FSR_T_BE_NS / `FSR_CLK_NS)
`define FSR_CE_CYC 16'(`FSR_T_CE_NS / `FSR_CLK_NS)

`endif

// >>> logic/fsr_pkg.sv
package fsr_pkg;

   // Decoded instructions handed over by the instruction sequencer.
   typedef enum logic [3:0] {
      FSR_CMD_WREN = 4'h0,
      FSR_CMD_WRDI = 4'h1,
      FSR_CMD_VWREN = 4'h2,
      FSR_CMD_WRSR = 4'h3,
      FSR_CMD_PROG = 4'h4,
      FSR_CMD_SE = 4'h5,
      FSR_CMD_BE = 4'h6,
      FSR_CMD_CE = 4'h7,
      FSR_CMD_SUSPEND = 4'h8,
      FSR_CMD_RESUME = 4'h9,
      FSR_CMD_RDSR = 4'ha,
      FSR_CMD_SWRESET = 4'hb,
      FSR_CMD_OTHER = 4'hf
   } fsr_cmd_t;

   // Gray coded along idle, busy, suspended.
   typedef enum logic [1:0] {
      FSR_ST_IDLE = 2'h0,
      FSR_ST_BUSY = 2'h1,
      FSR_ST_SUSP = 2'h3
   } fsr_state_t;

   typedef enum logic [1:0] {
      FSR_OP_NONE = 2'h0,
      FSR_OP_WRSR = 2'h1,
      FSR_OP_PROG = 2'h2,
      FSR_OP_ERASE = 2'h3
   } fsr_op_t;

endpackage

// >>> logic/fsr_op_if.sv
`timescale 1ns/100ps

// Link between the register bank and its embedded operation timer.
interface fsr_op_if;
   logic start;
   logic [15:0] count;
   logic pause;
   logic done;
   logic running;

   modport ctrl (output start, output count, output pause,
                 input done, input running);
   modport timer (input start, input count, input pause,
                  output done, output running);
endinterface

// >>> logic/fsr_op_timer.sv
`timescale 1ns/100ps

// Counts out one embedded operation; a pause freezes the count.
module fsr_op_timer import fsr_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control link
   fsr_op_if.timer opIf
);

   logic [15:0] remaining;
   logic lastCycle;

   assign lastCycle = (remaining == 16'h1);

   // A start always wins; done is a one-cycle pulse after the last count.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         remaining <= 16'h0;
         opIf.running <= 1'b0;
         opIf.done <= 1'b0;
      end else begin
         opIf.done <= 1'b0;
         if (opIf.start) begin
            remaining <= opIf.count;
            opIf.running <= 1'b1;
         end else if (opIf.running && !opIf.pause) begin
            remaining <= remaining - 16'h1;
            if (lastCycle) begin
               opIf.running <= 1'b0;
               opIf.done <= 1'b1;
            end
         end
      end
   end

endmodule // fsr_op_timer

// >>> logic/fsr_status_bank.sv
// Summary of operation
// - Bit 7 of register one lets the protect pin lock status writes.
// - Bit 6 of register one picks 64-kB blocks or 4-kB sectors.
// - Bit 5 of register one picks top-down or bottom-up protection.
// - Bits 4 to 2 of register one are block protect; zero protects none.
// - Bit 1 is the write enable latch; operations start only when set.
// - Bit 0 is busy, high while an embedded operation runs.
// - Busy is set during program, erase and stored status register write; a volatile status write leaves it low.
// - While busy, every instruction except status read and suspend of program or erase is ignored.
// - Busy clears when the program, erase or register write ends.
// - Write enable instruction sets the write enable latch.
// - Latch clears at reset, write disable, program, erase, status write.
// - Bit 7 of register two shows a suspended program or erase.
// - Bit 6 of register two selects the complementary protection map.
// - Bits 5 to 3 of register two are one-time security area locks.
// - Bit 1 of register two enables quad mode, disabling pin functions.
// - Reserved bits read as zero; the host hands them back whole.
// - Bit 7 of register three picks hold or reset pin, only without quad.
// - Bits 6 and 5 of register three select read driver strength.
// - Bit 4 of register three selects fast mode; defaults to one.
// - Reset loads factory values into both copies; software reset loads volatile copies from stored bits.
// - Volatile enable makes status writes touch only volatile copies.
// - Protect select high with protect pin low rejects all status writes while quad mode is off.
`timescale 1ns/100ps
`include "fsr_cfg.svh"

module fsr_status_bank import fsr_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Decoded instruction from the sequencer
   input wire logic cmdValid,
   input fsr_cmd_t cmdOp,
   input wire logic [1:0] cmdRegSel,
   input wire logic [7:0] cmdData,
   // Status register read port
   input wire logic rdReq,
   input wire logic [1:0] rdSel,
   output logic rdValid,
   output logic [7:0] rdData,
   // Write protect pin, asynchronous
   input wire logic wpPin_b,
   // Instruction outcome
   output logic cmdTaken,
   output logic cmdIgnored,
   // Progress flags
   output logic busy,
   output logic writeEnableLatch,
   output logic suspendFlag,
   // Configuration seen by the rest of the device
   output logic regProtectSelect,
   output logic granularitySelect,
   output logic protectDirection,
   output logic [2:0] blockProtect,
   output logic complementMap,
   output logic [2:0] secureLock,
   output logic quadEnable,
   output logic pinIsReset,
   output logic [1:0] driveStrength,
   output logic fastModeSelect
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Replace only the bits under the mask.
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] data,
                                        input logic [7:0] mask);
      merge = (old & ~mask) | (data & mask);
   endfunction

   // Length of each embedded operation in clock cycles.
   function automatic logic [15:0] opCycles(input fsr_cmd_t op);
      case (op)
         FSR_CMD_PROG: opCycles = `FSR_PROG_CYC;
         FSR_CMD_SE: opCycles = `FSR_SE_CYC;
         FSR_CMD_BE: opCycles = `FSR_BE_CYC;
         FSR_CMD_CE: opCycles = `FSR_CE_CYC;
         default: opCycles = `FSR_WRSR_CYC;
      endcase
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************

   fsr_state_t state, next_state;
   fsr_op_t opKind;
   logic wpSyncA, wpSync;
   logic vwrArmed, next_vwrArmed, next_wel;
   logic [7:0] nv1, nv2, nv3, vol1, vol2, vol3;
   logic [7:0] next_nv1, next_nv2, next_nv3;
   logic [7:0] next_vol1, next_vol2, next_vol3;
   logic [1:0] pendSel;
   logic [7:0] pendData;
   logic isBusy, isSusp, isIdle, isRdsr, isProgErase, isErase;
   logic suspOk, accept, startOp, wrsrTake, wrLocked;
   logic volWrite, nvWrite, swTake, commitNv;
   logic [7:0] sr1Live, sr2Live, sr3Live;

   fsr_op_if opIf();

   fsr_op_timer uTimer (
      .clk(clk),
      .rst_b(rst_b),
      .opIf(opIf)
   );

   // ****************************************************************
   // Protect pin synchroniser
   // ****************************************************************

   // The pin comes from the board, so two flops before any use.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wpSyncA <= 1'b1;
         wpSync <= 1'b1;
      end else begin
         wpSyncA <= wpPin_b;
         wpSync <= wpSyncA;
      end
   end

   // ****************************************************************
   // Instruction decode
   // ****************************************************************

   // Quad mode turns the protect pin into a data line, so it cannot lock.
   assign wrLocked = vol1[`FSR_BIT_SRP] & ~vol2[`FSR_BIT_QE] & ~wpSync;
   assign isBusy = (state == FSR_ST_BUSY);
   assign isSusp = (state == FSR_ST_SUSP);
   assign isIdle = (state == FSR_ST_IDLE);
   assign isRdsr = (cmdOp == FSR_CMD_RDSR);
   assign isErase = (cmdOp == FSR_CMD_SE) || (cmdOp == FSR_CMD_BE) ||
                    (cmdOp == FSR_CMD_CE);
   assign isProgErase = isErase || (cmdOp == FSR_CMD_PROG);
   assign suspOk = isBusy && ((opKind == FSR_OP_PROG) ||
                              (opKind == FSR_OP_ERASE));

   // While busy only a status read, or a suspend of program or erase,
   // gets through; while suspended no new embedded work may start.
   assign accept = cmdValid && (isBusy ?
                      (isRdsr || (cmdOp == FSR_CMD_SUSPEND && suspOk)) :
                   isSusp ?
                      !(isProgErase || cmdOp == FSR_CMD_WRSR ||
                        cmdOp == FSR_CMD_SUSPEND ||
                        cmdOp == FSR_CMD_SWRESET) :
                      (cmdOp != FSR_CMD_RESUME));

   assign startOp = accept && isProgErase && writeEnableLatch;
   assign wrsrTake = accept && (cmdOp == FSR_CMD_WRSR);
   assign volWrite = wrsrTake && vwrArmed && !wrLocked;
   assign nvWrite = wrsrTake && !vwrArmed && writeEnableLatch &&
                    !wrLocked;
   assign swTake = accept && (cmdOp == FSR_CMD_SWRESET);
   assign commitNv = opIf.done && (opKind == FSR_OP_WRSR);

   // Timer control; a suspended operation keeps its remaining count.
   assign opIf.start = startOp || nvWrite;
   assign opIf.count = opCycles(cmdOp);
   assign opIf.pause = isSusp;

   // ****************************************************************
   // Operation sequencing
   // ****************************************************************

   // Completion beats a suspend that lands in the same cycle.
   always_comb begin
      next_state = state;
      case (state)
         FSR_ST_IDLE: begin
            if (opIf.start) begin
               next_state = FSR_ST_BUSY;
            end
         end
         FSR_ST_BUSY: begin
            if (opIf.done) begin
               next_state = FSR_ST_IDLE;
            end else if (accept && cmdOp == FSR_CMD_SUSPEND) begin
               next_state = FSR_ST_SUSP;
            end
         end
         FSR_ST_SUSP: begin
            if (accept && cmdOp == FSR_CMD_RESUME) begin
               next_state = FSR_ST_BUSY;
            end
         end
         default: next_state = FSR_ST_IDLE;
      endcase
   end

   // Write enable latch: set by write enable, cleared by the listed work.
   always_comb begin
      next_wel = writeEnableLatch;
      if (swTake) begin
         next_wel = 1'b0;
      end else if (accept && cmdOp == FSR_CMD_WREN) begin
         next_wel = 1'b1;
      end else if (accept && (cmdOp == FSR_CMD_WRDI || isProgErase ||
                              cmdOp == FSR_CMD_WRSR)) begin
         next_wel = 1'b0;
      end
   end

   // The volatile enable reaches only the next accepted instruction other than a status read.
   assign next_vwrArmed = (accept && !isRdsr) ?
                          (cmdOp == FSR_CMD_VWREN) : vwrArmed;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= FSR_ST_IDLE;
         busy <= 1'b0;
         suspendFlag <= 1'b0;
         writeEnableLatch <= 1'b0;
         vwrArmed <= 1'b0;
      end else begin
         state <= next_state;
         busy <= (next_state == FSR_ST_BUSY);
         suspendFlag <= (next_state == FSR_ST_SUSP);
         writeEnableLatch <= next_wel;
         vwrArmed <= next_vwrArmed;
      end
   end

   // Remember what is running and what a stored write will commit.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         opKind <= FSR_OP_NONE;
         pendSel <= 2'h0;
         pendData <= 8'h00;
      end else if (opIf.start) begin
         opKind <= nvWrite ? FSR_OP_WRSR :
                   isErase ? FSR_OP_ERASE : FSR_OP_PROG;
         pendSel <= cmdRegSel;
         pendData <= cmdData;
      end
   end

   // ****************************************************************
   // Register contents
   // ****************************************************************

   // Stored bits change only when a stored write finishes; lock bits
   // can be set but never cleared again.
   assign next_nv1 = (commitNv && pendSel == `FSR_SEL_SR1) ?
                     merge(nv1, pendData, `FSR_SR1_MASK) : nv1;
   assign next_nv2 = (commitNv && pendSel == `FSR_SEL_SR2) ?
                     (merge(nv2, pendData, `FSR_SR2_MASK) |
                      (nv2 & `FSR_SR2_LBMASK)) : nv2;
   assign next_nv3 = (commitNv && pendSel == `FSR_SEL_SR3) ?
                     merge(nv3, pendData, `FSR_SR3_MASK) : nv3;

   // Volatile copies follow software reset, stored commits and
   // direct volatile writes; reserved positions never get set.
   assign next_vol1 = swTake ? nv1 :
                      commitNv ? next_nv1 :
                      (volWrite && cmdRegSel == `FSR_SEL_SR1) ?
                      merge(vol1, cmdData, `FSR_SR1_MASK) : vol1;
   assign next_vol2 = swTake ? (nv2 & `FSR_SR2_VMASK) :
                      commitNv ? (next_nv2 & `FSR_SR2_VMASK) :
                      (volWrite && cmdRegSel == `FSR_SEL_SR2) ?
                      merge(vol2, cmdData, `FSR_SR2_VMASK) : vol2;
   assign next_vol3 = swTake ? nv3 :
                      commitNv ? next_nv3 :
                      (volWrite && cmdRegSel == `FSR_SEL_SR3) ?
                      merge(vol3, cmdData, `FSR_SR3_MASK) : vol3;

   // Power-up loads the factory values into both copies.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         nv1 <= `FSR_SR1_RST;
         nv2 <= `FSR_SR2_RST;
         nv3 <= `FSR_SR3_RST;
         vol1 <= `FSR_SR1_RST;
         vol2 <= `FSR_SR2_RST;
         vol3 <= `FSR_SR3_RST;
      end else begin
         nv1 <= next_nv1;
         nv2 <= next_nv2;
         nv3 <= next_nv3;
         vol1 <= next_vol1;
         vol2 <= next_vol2;
         vol3 <= next_vol3;
      end
   end

   // The shared pin is a reset input only while quad mode is off.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pinIsReset <= 1'b0;
      end else begin
         pinIsReset <= next_vol3[`FSR_BIT_PAUSE_OR_RESET_PIN_SELECT] &
                       ~next_vol2[`FSR_BIT_QE];
      end
   end

   // Configuration outputs, each a bit of a volatile flop except secureLock, taken from the stored copy.
   assign regProtectSelect = vol1[`FSR_BIT_SRP];
   assign granularitySelect = vol1[`FSR_BIT_SEC];
   assign protectDirection = vol1[`FSR_BIT_TB];
   assign blockProtect = vol1[`FSR_BIT_BP_HI:`FSR_BIT_BP_LO];
   assign complementMap = vol2[`FSR_BIT_CMP];
   assign secureLock = nv2[`FSR_BIT_LB_HI:`FSR_BIT_LB_LO];
   assign quadEnable = vol2[`FSR_BIT_QE];
   assign driveStrength = vol3[`FSR_BIT_DRV_HI:`FSR_BIT_DRV_LO];
   assign fastModeSelect = vol3[`FSR_BIT_HFM];

   // ****************************************************************
   // Status read
   // ****************************************************************

   // Flags are taken live, so a poll during busy sees progress.
   assign sr1Live = {vol1[7:2], writeEnableLatch, busy};
   assign sr2Live = {suspendFlag, vol2[`FSR_BIT_CMP],
                     nv2[`FSR_BIT_LB_HI:`FSR_BIT_LB_LO], 1'b0,
                     vol2[`FSR_BIT_QE], 1'b0};
   assign sr3Live = {vol3[7:4], 4'h0};

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdValid <= 1'b0;
         rdData <= 8'h00;
         cmdTaken <= 1'b0;
         cmdIgnored <= 1'b0;
      end else begin
         rdValid <= rdReq;
         rdData <= (rdSel == `FSR_SEL_SR1) ? sr1Live :
                   (rdSel == `FSR_SEL_SR2) ? sr2Live :
                   (rdSel == `FSR_SEL_SR3) ? sr3Live : 8'h00;
         cmdTaken <= accept;
         cmdIgnored <= cmdValid && !accept;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************

   logic [1:0] rdSelQ;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdSelQ <= 2'h0;
      end else begin
         rdSelQ <= rdSel;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence seqWrenIdle;
      cmdValid && cmdOp == FSR_CMD_WREN && isIdle;
   endsequence

   sequence seqProgStart;
      cmdValid && cmdOp == FSR_CMD_PROG && isIdle && writeEnableLatch;
   endsequence

   sequence seqSuspend;
      cmdValid && cmdOp == FSR_CMD_SUSPEND && suspOk && !opIf.done;
   endsequence

   prog_sets_busy_a: assert property (seqProgStart |=> busy && !writeEnableLatch [*2])
      else $error("program start did not raise busy");

   busy_ignores_a: assert property (cmdValid && isBusy && !isRdsr &&
         cmdOp != FSR_CMD_SUSPEND |=> cmdIgnored && !cmdTaken)
      else $error("instruction taken while busy");

   done_clears_busy_a: assert property (opIf.done && isBusy |=> !busy)
      else $error("busy stayed high after completion");

   wren_sets_wel_a: assert property (seqWrenIdle |=> writeEnableLatch)
      else $error("write enable did not set the latch");

   wrdi_clears_wel_a: assert property (cmdValid && cmdOp == FSR_CMD_WRDI
         && !isBusy |=> !writeEnableLatch)
      else $error("write disable left the latch set");

   prog_needs_wel_a: assert property (cmdValid && cmdOp == FSR_CMD_PROG
         && isIdle && !writeEnableLatch |=> !busy [*2])
      else $error("program started without write enable");

   locked_write_a: assert property (wrsrTake && wrLocked |=>
         $stable(vol1) && $stable(vol3) && !busy)
      else $error("status write passed a hardware lock");

   suspend_flag_a: assert property (seqSuspend |=> suspendFlag && !busy)
      else $error("suspend did not show in the flag");

   reserved_zero_a: assert property (rdValid && rdSelQ == `FSR_SEL_SR2
         |-> rdData[0] == 1'b0 && rdData[2] == 1'b0)
      else $error("reserved status bit read as one");

   live_flags_a: assert property (rdValid && rdSelQ == `FSR_SEL_SR1 |->
         rdData[1:0] == $past({writeEnableLatch, busy}))
      else $error("status read returned stale flags");

   reset_pin_a: assert property (pinIsReset |-> !quadEnable)
      else $error("reset pin selected while quad enabled");

endmodule // fsr_status_bank

// >>> dv/fsr_host.sv
`timescale 1ns/100ps

// ****************************************************************
// Host controller model: one instruction or one read at a time.
// ****************************************************************
module fsr_host import fsr_pkg::*; (
   // Clock
   input wire logic clk,
   // Instruction side
   output logic cmdValid,
   output fsr_cmd_t cmdOp,
   output logic [1:0] cmdRegSel,
   output logic [7:0] cmdData,
   input wire logic cmdTaken,
   // Read side
   output logic rdReq,
   output logic [1:0] rdSel,
   input wire logic rdValid,
   input wire logic [7:0] rdData
);
   // Quiet lines at time zero.
   initial begin
      cmdValid = 1'b0;
      cmdOp = FSR_CMD_OTHER;
      cmdRegSel = 2'h0;
      cmdData = 8'h00;
      rdReq = 1'b0;
      rdSel = 2'h0;
   end

   // The answer stands one cycle, so it is taken at the next fall.
   task automatic issue(input fsr_cmd_t op, input logic [1:0] s,
                        input logic [7:0] x, output logic ok);
      @(negedge clk);
      cmdValid = 1'b1;
      cmdOp = op;
      cmdRegSel = s;
      cmdData = x;
      @(negedge clk);
      ok = cmdTaken;
      cmdValid = 1'b0;
      cmdData = ~x; // Stale data is inverted so it is never trusted.
   endtask

   // Reserved bits go back whole; the caller decides what they mean.
   task automatic fetch(input logic [1:0] s, output logic [7:0] d,
                        output logic v);
      @(negedge clk);
      rdReq = 1'b1;
      rdSel = s;
      @(negedge clk);
      v = rdValid;
      d = rdData;
      rdReq = 1'b0;
      rdSel = ~s;
   endtask
endmodule // fsr_host

// >>> dv/flash_status_register_bank_test.sv
`timescale 1ns/100ps

// ****************************************************************
// Self-checking bench with a register model.
// ****************************************************************
module flash_status_register_bank_test import fsr_pkg::*; ;
   logic clk, rst_b, wpPin_b, cmdValid, cmdTaken, rdReq, rdValid;
   logic busy, write_enable_latch, suspend_flag, mw, mb, msus, vol, ok, v, ign;
   fsr_cmd_t cmdOp;
   logic [1:0] cmdRegSel, rdSel, ps;
   logic [7:0] cmdData, rdData, d, pd;
   logic [7:0] mv [1:3];
   logic [7:0] ms [1:2];
   logic [2:0] lb;
   logic [14:0] cfg;
   int fail_count, compares, cyc, t0;

   fsr_status_bank dut (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
      .cmdOp(cmdOp), .cmdRegSel(cmdRegSel), .cmdData(cmdData),
      .rdReq(rdReq), .rdSel(rdSel), .rdValid(rdValid), .rdData(rdData),
      .wpPin_b(wpPin_b), .cmdTaken(cmdTaken), .cmdIgnored(ign), .busy(busy),
      .writeEnableLatch(write_enable_latch), .suspendFlag(suspend_flag),
      .regProtectSelect(cfg[14]), .granularitySelect(cfg[13]),
      .protectDirection(cfg[12]), .blockProtect(cfg[11:9]),
      .complementMap(cfg[8]), .secureLock(cfg[7:5]), .quadEnable(cfg[4]),
      .pinIsReset(cfg[3]), .driveStrength(cfg[2:1]),
      .fastModeSelect(cfg[0]));
   fsr_host host (.clk(clk), .cmdValid(cmdValid), .cmdOp(cmdOp),
      .cmdRegSel(cmdRegSel), .cmdData(cmdData), .cmdTaken(cmdTaken),
      .rdReq(rdReq), .rdSel(rdSel), .rdValid(rdValid), .rdData(rdData));

   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Cycle count, so a busy span is timed from its start, not its poll.
   always @(posedge clk) cyc <= cyc + 1;

   task automatic results();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] want);
      compares++;
      if (got !== want) begin
         fail_count++;
         $display("wrong value at %0t: %h expected %h", $time, got, want);
      end
   endtask

   function automatic logic [7:0] vm(input logic [1:0] s);
      return s == 2'h1 ? 8'hfc : s == 2'h2 ? 8'h42 : 8'hf0;
   endfunction

   // One read compared with the model view of that register.
   task automatic rd(input logic [1:0] s);
      logic [7:0] w;
      logic [14:0] e;
      w = s == 2'h1 ? {mv[1][7:2], mw, mb} : s == 2'h3 ? mv[3] :
          s == 2'h2 ? {msus, mv[2][6], lb, 1'b0, mv[2][1], 1'b0} : 8'h00;
      host.fetch(s, d, v);
      check({15'h0, v}, 16'h1);
      check({8'h0, d}, {8'h0, w});
      e = {mv[1][7:2], mv[2][6], lb, mv[2][1], mv[3][7] & ~mv[2][1],
           mv[3][6:4]};
      check({1'b0, cfg}, {1'b0, e});
   endtask

   // Sends one instruction and steps the model as the device should.
   task automatic cmd(input fsr_cmd_t op, input logic [1:0] s,
                      input logic [7:0] x, input logic take);
      logic lk;
      lk = mv[1][7] && !wpPin_b && !mv[2][1];
      host.issue(op, s, x, ok);
      check({14'h0, ok, ign}, {14'h0, take, !take});
      if (take) begin
         case (op)
            FSR_CMD_WREN: mw = 1'b1;
            FSR_CMD_WRDI: mw = 1'b0;
            FSR_CMD_PROG, FSR_CMD_SE: mb = mw;
            FSR_CMD_SUSPEND: {mb, msus} = 2'b01;
            FSR_CMD_RESUME: {mb, msus} = 2'b10;
            FSR_CMD_SWRESET: mv[1:2] = ms;
            FSR_CMD_WRSR: if (!lk && vol) begin
               mv[s] = (mv[s] & ~vm(s)) | (x & vm(s));
            end else if (!lk && mw) begin
               {mb, ps, pd} = {1'b1, s, x};
            end
            default: ;
         endcase
         if (op inside {FSR_CMD_WRSR, FSR_CMD_PROG, FSR_CMD_SE})
            mw = 1'b0;
         vol = op == FSR_CMD_VWREN;
         if (mb)
            t0 = cyc;
      end
      check({13'h0, write_enable_latch, busy, suspend_flag}, {13'h0, mw, mb, msus});
   endtask

   // Waits out an embedded operation; n is its busy span, 0 skips it.
   task automatic settle(input int n);
      int i;
      for (i = 0; i < 5000 && busy !== 1'b0; i++)
         @(negedge clk);
      if (n != 0)
         check(16'(cyc - t0), 16'(n));
      mb = 1'b0;
      if (ps != 2'h0) begin
         lb = lb | (ps == 2'h2 ? pd[5:3] : 3'h0);
         ms[ps] = pd & vm(ps);
         mv[ps] = ms[ps];
      end
      ps = 2'h0;
      rd(2'h1);
   endtask

   // A hang is cut short and counted.
   initial begin
      #1000000;
      fail_count++;
      results();
   end

   // Main sequence.
   initial begin
      {rst_b, wpPin_b, mw, mb, msus, vol, ps, lb} = 11'h200;
      {mv[1], mv[2], mv[3], ms[1], ms[2]} = 40'h0000100000;
      void'($urandom(32'hf9948cf8));
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      for (int s = 0; s < 4; s++)
         rd(2'(s));
      cmd(FSR_CMD_WREN, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_WRDI, 2'h0, 8'h00, 1'b1);
      for (int s = 1; s < 4; s++) begin
         cmd(FSR_CMD_VWREN, 2'h0, 8'h00, 1'b1);
         cmd(FSR_CMD_WRSR, 2'(s), 8'($urandom), 1'b1);
         rd(2'(s));
      end
      cmd(FSR_CMD_VWREN, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_WRSR, 2'h3, 8'h10, 1'b1);
      cmd(FSR_CMD_SWRESET, 2'h0, 8'h00, 1'b1);
      rd(2'h2);
      cmd(FSR_CMD_WREN, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_PROG, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_WREN, 2'h0, 8'h00, 1'b0);
      rd(2'h1);
      settle(`FSR_PROG_CYC + 1);
      cmd(FSR_CMD_PROG, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_WREN, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_SE, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_SUSPEND, 2'h0, 8'h00, 1'b1);
      rd(2'h2);
      cmd(FSR_CMD_RESUME, 2'h0, 8'h00, 1'b1);
      settle(0);
      for (int i = 2; i >= 0; i--) begin
         cmd(FSR_CMD_WREN, 2'h0, 8'h00, 1'b1);
         cmd(FSR_CMD_WRSR, i == 2 ? 2'h1 : 2'h2, 8'h08 << i, 1'b1);
         settle(`FSR_WRSR_CYC + 1);
         rd(2'h2);
      end
      wpPin_b = 1'b0;
      repeat (3) @(negedge clk);
      cmd(FSR_CMD_VWREN, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_WRSR, 2'h1, 8'h80, 1'b1);
      cmd(FSR_CMD_VWREN, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_WRSR, 2'h3, 8'h00, 1'b1);
      rd(2'h3);
      cmd(FSR_CMD_WREN, 2'h0, 8'h00, 1'b1);
      cmd(FSR_CMD_WRSR, 2'h1, 8'h00, 1'b1);
      rd(2'h1);
      results();
   end
endmodule // flash_status_register_bank_test
